// file: rim_board.sv
`timescale 1ns/1ps
// Board side of the reset line: pull-up plus an external reset switch
module rim_board (
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic go_i,
	input wire logic [3:0] len_i,
	output logic pin_o
);
	logic [3:0] cnt_r = 4'h0;
	// Switch holds the line low for len_i cycles after go_i
	always_ff @(posedge clk_i) begin
		if (go_i)
			cnt_r <= len_i;
		else if (cnt_r != 4'h0)
			cnt_r <= cnt_r - 4'h1;
	end
	// Wired-and with pull-up, so a released line reads high, never stale
	assign pin_o = !(oe_i || cnt_r != 4'h0);
endmodule // rim_board

// file: rim_pkg.sv
package rim_pkg;

	// Clock rate and the derived cycle figures
	localparam int unsigned CLK_PERIOD_PS = 50000;
	// Least width of the reset pulse driven on the pin, plain default
	localparam int unsigned MIN_OUT_NS = 30000;
	// Least time, so rounded up to whole cycles
	localparam int unsigned MIN_OUT_CYC =
		(MIN_OUT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DLY_SHORT = 256;
	localparam int unsigned DLY_LONG = 4096;
	localparam int unsigned FETCH_CYC = 2;
	localparam int unsigned GLITCH_CYC = 4;
	localparam int unsigned CNT_W = 13;

	// Reset service routine vector location
	localparam logic [15:0] VEC_LO = 16'hFFFE;

	// Register map, byte addresses
	localparam int unsigned AXI_AW = 4;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SEQ = 4'h4;

	// Field positions in integrity_ctrl_status
	localparam int unsigned BIT_WARN_IE = 6;
	localparam int unsigned BIT_WARN_F = 5;
	localparam int unsigned BIT_LVD_RF = 4;
	localparam int unsigned BIT_GUARD_IE = 2;
	localparam int unsigned BIT_FAIL_F = 1;
	localparam int unsigned BIT_WDG_RF = 0;
	// Field positions in the sequencer status register
	localparam int unsigned BIT_SEQ_DRIVE = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		SEQ_ACTIVE,
		SEQ_DELAY,
		SEQ_FETCH,
		SEQ_RUN
	} rim_state_t;

	// Non-volatile configuration options
	typedef struct packed {
		logic long_delay;
		logic lvd_en;
		logic doubler_en;
		logic guard_en;
	} rim_opt_t;

endpackage

// file: rim_top.sv
// Summary of operation
// - Pin, supply detector and watchdog requests all reset; pin held low through delay.
// - After reset, the vector is fetched from the two top addresses.
// - Each reset runs active phase, then stabilisation delay, then vector fetch.
// - Stabilisation delay is 256 or 4096 cycles, chosen by an option.
// - Vector fetch takes exactly two cycles before execution starts.
// - Reset pin is an input and an open-drain output with pull-up.
// - Low level on the pin enters reset with no clock needed.
// - A recognised pin pulse is stretched to the least output width.
// - Watchdog underflow drives the pin low for the least output width.
// - Supply detector holds reset while supply is below its hysteretic threshold.
// - Pin stays low for as long as the supply reset lasts.
// - Supply detector is enabled or disabled by an option.
// - Supply warning comparator output is a read-only live status bit.
// - Supply warning monitor works only when the supply detector is enabled.
// - Enabled warning interrupt fires on every toggle of the warning flag.
// - No warning interrupt for a crossing inside the reset delay.
// - Enabling while below threshold gives one interrupt now, one at crossing.
// - Enabling after the threshold was reached gives no interrupt until the next toggle.
// - Clock guard filters oscillator glitches, only with the doubler enabled.
// - Lost oscillator switches to the safe clock, and back on recovery.
// - Failover flag set while on safe clock; cleared by read after recovery.
// - Watchdog flag set by watchdog, cleared by zero write or supply reset.
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module rim_top #(
	parameter int unsigned DLY_SHORT = rim_pkg::DLY_SHORT,
	parameter int unsigned DLY_LONG = rim_pkg::DLY_LONG,
	parameter int unsigned MIN_OUT_CYC = rim_pkg::MIN_OUT_CYC,
	parameter int unsigned GLITCH_CYC = rim_pkg::GLITCH_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire rim_pkg::rim_opt_t opt_i,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	input wire logic lvd_below_i,
	input wire logic avd_below_i,
	input wire logic wdg_underflow_i,
	input wire logic osc_ok_i,
	input wire logic warn_irq_ack_i,
	output logic cpu_rst_o,
	output logic vec_fetch_o,
	output logic [15:0] vec_addr_o,
	output logic safe_clk_sel_o,
	output logic warn_irq_o,
	output logic guard_irq_o,
	input wire logic [rim_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [rim_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	localparam int unsigned W = rim_pkg::CNT_W;

	// Reset release through two flops
	logic [1:0] rst_sync_r;
	logic rst_ok;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_ok = rst_sync_r[1];

	// Pin is open drain: output level fixed low, only the enable moves
	logic drive_r, drive_d_r, ext_clr_n;
	logic [1:0] ext_sync_r;
	assign rst_pin_o = 1'b0;
	// Own drive masks the pin, one extra cycle covers the pull-up rise
	assign ext_clr_n = rst_pin_i | drive_r | drive_d_r;
	// Async entry, synchronous release; works with the clock stopped
	always_ff @(posedge sys_clk_i or negedge ext_clr_n) begin
		if (!ext_clr_n) begin
			ext_sync_r <= 2'h0;
		end else if (ce_i) begin
			ext_sync_r <= {ext_sync_r[0], 1'b1};
		end
	end

	// Analog comparators and oscillator detector, two-flop synchronisers
	logic [2:0] s1_r, s2_r;
	logic lvd_s, avd_s, osc_s;
	always_ff @(posedge sys_clk_i or negedge rst_ok) begin
		if (!rst_ok) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
		end else if (ce_i) begin
			s1_r <= {lvd_below_i, avd_below_i, osc_ok_i};
			s2_r <= s1_r;
		end
	end
	assign {lvd_s, avd_s, osc_s} = s2_r;

	// Clock guard: glitch filter and safe clock selection
	logic [W-1:0] gf_cnt_r, gf_cnt_nxt;
	logic osc_filt_r, osc_filt_nxt, safe_r, safe_nxt;
	always_comb begin
		gf_cnt_nxt = '0;
		osc_filt_nxt = osc_filt_r;
		if (!opt_i.doubler_en) begin
			osc_filt_nxt = osc_s;
		end else if (osc_s != osc_filt_r) begin
			// Change is taken only after a run of equal samples
			if (gf_cnt_r == W'(GLITCH_CYC - 1)) begin
				osc_filt_nxt = osc_s;
			end else begin
				gf_cnt_nxt = gf_cnt_r + W'(1);
			end
		end
		safe_nxt = opt_i.guard_en & ~osc_filt_nxt;
	end
	always_ff @(posedge sys_clk_i or negedge rst_ok) begin
		if (!rst_ok) begin
			gf_cnt_r <= '0;
			osc_filt_r <= 1'b1;
			safe_r <= 1'b0;
		end else if (ce_i) begin
			gf_cnt_r <= gf_cnt_nxt;
			osc_filt_r <= osc_filt_nxt;
			safe_r <= safe_nxt;
		end
	end
	assign safe_clk_sel_o = safe_r;

	// Reset sequencer
	rim_pkg::rim_state_t state_r, state_nxt;
	logic [W-1:0] cnt_r, cnt_nxt, str_r, str_nxt, dly_last;
	logic [15:0] vec_r, vec_nxt;
	logic ext_low, ext_prev_r, ext_fall, lvd_act, kick, src_act, drive_nxt;
	assign ext_low = ~ext_sync_r[1];
	assign ext_fall = ext_low & ~ext_prev_r;
	assign lvd_act = opt_i.lvd_en & lvd_s;
	assign kick = ext_fall | wdg_underflow_i;
	assign dly_last = opt_i.long_delay ? W'(DLY_LONG - 1) : W'(DLY_SHORT - 1);
	assign src_act = ext_low | lvd_act | kick | (str_r != '0);
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		// Stretch pin and watchdog pulses to the least output width
		str_nxt = (str_r != '0) ? str_r - W'(1) : '0;
		if (kick) begin
			str_nxt = W'(MIN_OUT_CYC);
		end
		case (state_r)
			rim_pkg::SEQ_ACTIVE: begin
				if (!src_act) begin
					state_nxt = rim_pkg::SEQ_DELAY;
					cnt_nxt = dly_last;
				end
			end
			rim_pkg::SEQ_DELAY: begin
				if (src_act) begin
					state_nxt = rim_pkg::SEQ_ACTIVE;
				end else if (cnt_r == '0) begin
					state_nxt = rim_pkg::SEQ_FETCH;
				end else begin
					cnt_nxt = cnt_r - W'(1);
				end
			end
			rim_pkg::SEQ_FETCH: begin
				if (src_act) begin
					state_nxt = rim_pkg::SEQ_ACTIVE;
				end else if (cnt_r == W'(rim_pkg::FETCH_CYC - 1)) begin
					state_nxt = rim_pkg::SEQ_RUN;
				end else begin
					cnt_nxt = cnt_r + W'(1);
				end
			end
			default: begin
				if (src_act) begin
					state_nxt = rim_pkg::SEQ_ACTIVE;
				end
			end
		endcase
		drive_nxt = (state_nxt == rim_pkg::SEQ_ACTIVE) ||
			(state_nxt == rim_pkg::SEQ_DELAY);
		vec_nxt = '0;
		if (state_nxt == rim_pkg::SEQ_FETCH) begin
			vec_nxt = rim_pkg::VEC_LO + 16'(cnt_nxt);
		end
	end
	// Power-up starts in the active phase so the delay always runs
	always_ff @(posedge sys_clk_i or negedge rst_ok) begin
		if (!rst_ok) begin
			state_r <= rim_pkg::SEQ_ACTIVE;
			cnt_r <= '0;
			str_r <= '0;
			vec_r <= '0;
			ext_prev_r <= 1'b0;
			drive_r <= 1'b1;
			drive_d_r <= 1'b1;
		end else if (ce_i) begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			str_r <= str_nxt;
			vec_r <= vec_nxt;
			ext_prev_r <= ext_low;
			drive_r <= drive_nxt;
			drive_d_r <= drive_r;
		end
	end
	assign rst_pin_oe_o = drive_r;
	// Pin term keeps the core in reset even with the clock halted
	assign cpu_rst_o = (state_r != rim_pkg::SEQ_RUN) | ext_low;
	assign vec_fetch_o = (state_r == rim_pkg::SEQ_FETCH);
	assign vec_addr_o = vec_r;

	// Register bus: write address and data latched in either order
	logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt, wr_fire, rd_ctrl;
	logic [rim_pkg::AXI_AW-1:0] awa_r, awa_nxt;
	logic [7:0] wd_r, wd_nxt;
	logic ws_r, ws_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt, ctrl_v;
	logic wr_ctrl, warn_f;
	logic ie_r, ie_nxt, gie_r, gie_nxt, lrf_r, lrf_nxt, wrf_r, wrf_nxt;
	logic fail_r, fail_nxt, pend_r, pend_nxt, warn_prev_r, ie_prev_r;
	assign s_axi_awready = ~aw_r & ~b_r;
	assign s_axi_wready = ~w_r & ~b_r;
	assign s_axi_arready = ~r_r;
	assign wr_fire = aw_r & w_r;
	assign wr_ctrl = wr_fire & ws_r &
		(awa_r[rim_pkg::AXI_AW-1:2] == rim_pkg::ADDR_CTRL[rim_pkg::AXI_AW-1:2]);
	assign rd_ctrl = s_axi_arvalid & ~r_r &
		(s_axi_araddr[rim_pkg::AXI_AW-1:2] ==
		rim_pkg::ADDR_CTRL[rim_pkg::AXI_AW-1:2]);
	// Live comparator view, dead when the supply detector is off
	assign warn_f = opt_i.lvd_en & avd_s;
	always_comb begin
		ctrl_v = '0;
		ctrl_v[rim_pkg::BIT_WARN_IE] = ie_r;
		ctrl_v[rim_pkg::BIT_WARN_F] = warn_f;
		ctrl_v[rim_pkg::BIT_LVD_RF] = lrf_r;
		ctrl_v[rim_pkg::BIT_GUARD_IE] = gie_r;
		ctrl_v[rim_pkg::BIT_FAIL_F] = fail_r;
		ctrl_v[rim_pkg::BIT_WDG_RF] = wrf_r;
		aw_nxt = aw_r;
		awa_nxt = awa_r;
		w_nxt = w_r;
		wd_nxt = wd_r;
		ws_nxt = ws_r;
		b_nxt = b_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = 1'b1;
			awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt = 1'b1;
			wd_nxt = s_axi_wdata[7:0];
			ws_nxt = s_axi_wstrb[0];
		end
		if (wr_fire) begin
			aw_nxt = 1'b0;
			w_nxt = 1'b0;
			b_nxt = 1'b1;
			bresp_nxt = rim_pkg::RESP_SLVERR;
			if (awa_r[rim_pkg::AXI_AW-1:2] ==
				rim_pkg::ADDR_CTRL[rim_pkg::AXI_AW-1:2] ||
				awa_r[rim_pkg::AXI_AW-1:2] ==
				rim_pkg::ADDR_SEQ[rim_pkg::AXI_AW-1:2]) begin
				bresp_nxt = rim_pkg::RESP_OKAY;
			end
		end else if (b_r && s_axi_bready) begin
			b_nxt = 1'b0;
		end
		r_nxt = r_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (s_axi_arvalid && !r_r) begin
			r_nxt = 1'b1;
			rdata_nxt = '0;
			rresp_nxt = rim_pkg::RESP_OKAY;
			if (rd_ctrl) begin
				rdata_nxt = ctrl_v;
			end else if (s_axi_araddr[rim_pkg::AXI_AW-1:2] ==
				rim_pkg::ADDR_SEQ[rim_pkg::AXI_AW-1:2]) begin
				rdata_nxt[1:0] = 2'(state_r);
				rdata_nxt[rim_pkg::BIT_SEQ_DRIVE] = drive_r;
			end else begin
				rresp_nxt = rim_pkg::RESP_SLVERR;
			end
		end else if (r_r && s_axi_rready) begin
			r_nxt = 1'b0;
		end
	end

	// Flags and enables; hardware set always wins over a clear
	always_comb begin
		ie_nxt = wr_ctrl ? wd_r[rim_pkg::BIT_WARN_IE] : ie_r;
		gie_nxt = wr_ctrl ? wd_r[rim_pkg::BIT_GUARD_IE] : gie_r;
		lrf_nxt = lrf_r;
		if (wr_ctrl && !wd_r[rim_pkg::BIT_LVD_RF]) begin
			lrf_nxt = 1'b0;
		end
		if (lvd_act) begin
			lrf_nxt = 1'b1;
		end
		wrf_nxt = wrf_r;
		if ((wr_ctrl && !wd_r[rim_pkg::BIT_WDG_RF]) || lvd_act) begin
			wrf_nxt = 1'b0;
		end
		if (wdg_underflow_i) begin
			wrf_nxt = 1'b1;
		end
		// Read clears only once the main oscillator is back
		fail_nxt = (fail_r & ~rd_ctrl) | safe_r;
		if (!opt_i.guard_en) begin
			fail_nxt = 1'b0;
		end
		// Toggles inside reset or delay are absorbed, not queued
		pend_nxt = pend_r & ~warn_irq_ack_i;
		if (state_r == rim_pkg::SEQ_RUN && ie_r &&
			((warn_f != warn_prev_r) ||
			(!ie_prev_r && warn_f))) begin
			pend_nxt = 1'b1;
		end
	end
	always_ff @(posedge sys_clk_i or negedge rst_ok) begin
		if (!rst_ok) begin
			aw_r <= 1'b0;
			awa_r <= '0;
			w_r <= 1'b0;
			wd_r <= 8'h00;
			ws_r <= 1'b0;
			b_r <= 1'b0;
			bresp_r <= rim_pkg::RESP_OKAY;
			r_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= rim_pkg::RESP_OKAY;
			ie_r <= 1'b0;
			gie_r <= 1'b0;
			lrf_r <= 1'b0;
			wrf_r <= 1'b0;
			fail_r <= 1'b0;
			pend_r <= 1'b0;
			warn_prev_r <= 1'b0;
			ie_prev_r <= 1'b0;
		end else if (ce_i) begin
			aw_r <= aw_nxt;
			awa_r <= awa_nxt;
			w_r <= w_nxt;
			wd_r <= wd_nxt;
			ws_r <= ws_nxt;
			b_r <= b_nxt;
			bresp_r <= bresp_nxt;
			r_r <= r_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			ie_r <= ie_nxt;
			gie_r <= gie_nxt;
			lrf_r <= lrf_nxt;
			wrf_r <= wrf_nxt;
			fail_r <= fail_nxt;
			pend_r <= pend_nxt;
			warn_prev_r <= warn_f;
			ie_prev_r <= ie_r;
		end
	end
	assign s_axi_bvalid = b_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = r_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign warn_irq_o = pend_r;
	assign guard_irq_o = fail_r & gie_r & opt_i.guard_en;

	// Checks; clock enable must stay high while they are meaningful
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_ok || !ce_i);
	logic [W-1:0] dly_seen_r;
	always_ff @(posedge sys_clk_i or negedge rst_ok) begin
		if (!rst_ok) begin
			dly_seen_r <= '0;
		end else if (ce_i) begin
			dly_seen_r <= (state_r == rim_pkg::SEQ_DELAY) ?
				dly_seen_r + W'(1) : '0;
		end
	end
	sequence fetch_entry_s;
		$rose(vec_fetch_o);
	endsequence
	sequence fetch_body_s;
		vec_fetch_o[*2] ##1 !vec_fetch_o;
	endsequence
	pin_in_delay_a: assert property (
		state_r == rim_pkg::SEQ_DELAY |-> rst_pin_oe_o)
		else $error("pin released during delay");
	// A source raised in the first fetch cycle aborts the fetch legally
	vector_addr_a: assert property (
		fetch_entry_s ##0 !src_act |-> vec_addr_o == rim_pkg::VEC_LO ##1
		vec_addr_o == rim_pkg::VEC_LO + 16'h0001)
		else $error("wrong vector address");
	phase_order_a: assert property (
		$rose(state_r == rim_pkg::SEQ_RUN) |->
		$past(state_r) == rim_pkg::SEQ_FETCH)
		else $error("run entered without fetch");
	delay_length_a: assert property (
		state_r == rim_pkg::SEQ_DELAY &&
		state_nxt == rim_pkg::SEQ_FETCH |-> dly_seen_r == dly_last)
		else $error("delay length wrong");
	// Body is checked from the first fetch cycle on
	fetch_cycles_a: assert property (
		fetch_entry_s ##0 !src_act |-> fetch_body_s)
		else $error("fetch not two cycles");
	pin_async_a: assert property (
		!ext_sync_r[1] |-> cpu_rst_o)
		else $error("pin low without core reset");
	stretch_a: assert property (
		kick |=> str_r == W'(MIN_OUT_CYC) ##1 rst_pin_oe_o)
		else $error("reset pulse not stretched");
	lvd_hold_a: assert property (
		lvd_act |=> rst_pin_oe_o [*2])
		else $error("pin not held in supply reset");
	warn_gate_a: assert property (
		!opt_i.lvd_en |-> !ctrl_v[rim_pkg::BIT_WARN_F])
		else $error("warning flag live while disabled");
	no_reset_irq_a: assert property (
		state_r != rim_pkg::SEQ_RUN && !pend_r |=> !pend_r)
		else $error("warning interrupt inside reset");
	wdg_flag_a: assert property (
		wdg_underflow_i |=> wrf_r)
		else $error("watchdog flag not set");
	failover_a: assert property (
		safe_r |=> fail_r)
		else $error("failover flag not set");
endmodule // rim_top

// file: rim_top_tb.sv
`timescale 1ns/1ps
module rim_top_tb;
	localparam int DS = 8;
	localparam int DL = 16;
	localparam int MO = 4;
	localparam logic [3:0] AC = rim_pkg::ADDR_CTRL;
	localparam logic [3:0] AS = rim_pkg::ADDR_SEQ;
	localparam logic [33:0] FM = {34{1'h1}};
	logic sys_clk_i = 1'h0, rst_n_i = 1'h0, ce_i = 1'h1;
	logic rst_pin_i, rst_pin_o, rst_pin_oe_o, go = 1'h0;
	logic lvd_below_i = 1'h0, avd_below_i = 1'h0, osc_ok_i = 1'h1;
	logic wdg_underflow_i = 1'h0, warn_irq_ack_i = 1'h0;
	logic cpu_rst_o, vec_fetch_o, safe_clk_sel_o, warn_irq_o, guard_irq_o;
	logic [15:0] vec_addr_o;
	logic [3:0] plen = 4'h1;
	rim_pkg::rim_opt_t opt_i = 4'h4;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h1;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	int errors = 0, check_count = 0, span = 0, last_span = 0, len;
	logic [67:0] exp_q[$];

	rim_top #(.DLY_SHORT(DS), .DLY_LONG(DL), .MIN_OUT_CYC(MO),
		.GLITCH_CYC(4)) rim_top_i (.sys_clk_i, .rst_n_i, .ce_i, .opt_i,
		.rst_pin_i, .rst_pin_o, .rst_pin_oe_o, .lvd_below_i, .avd_below_i,
		.wdg_underflow_i, .osc_ok_i, .warn_irq_ack_i, .cpu_rst_o,
		.vec_fetch_o, .vec_addr_o, .safe_clk_sel_o, .warn_irq_o,
		.guard_irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	rim_board rim_board_i (.clk_i(sys_clk_i), .oe_i(rst_pin_oe_o),
		.go_i(go), .len_i(plen), .pin_o(rst_pin_i));

	// 20 MHz clock
	initial forever #25 sys_clk_i = !sys_clk_i;

	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		check_count++;
		if (seen !== want) begin
			errors++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic ok(input logic c);
		check({33'h0, c}, 34'h1);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	// Write: address and data offered together, each released when taken
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		// Only the two mapped words answer OKAY
		exp_q.push_back({FM, ((a == AC || a == AS) ? rim_pkg::RESP_OKAY :
			rim_pkg::RESP_SLVERR), 32'h0});
		@(posedge sys_clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge sys_clk_i);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask

	// Read: note {resp,data} under a mask, the monitor compares it
	task automatic rd(input logic [3:0] a, input logic [33:0] m,
		input logic [33:0] x);
		exp_q.push_back({m, x});
		@(posedge sys_clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge sys_clk_i);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
	endtask

	// Follow one reset to run; pin drive span must fit lo..hi
	task automatic seq(input int lo, input int hi);
		exp_q.push_back({FM, 34'h0_FFFE});
		exp_q.push_back({FM, 34'h0_FFFF});
		do @(posedge sys_clk_i); while (cpu_rst_o !== 1'h1);
		do @(posedge sys_clk_i); while (cpu_rst_o !== 1'h0);
		tick(2);
		ok(last_span >= lo && last_span <= hi);
		check(34'(exp_q.size()), 34'h0);
	endtask

	task automatic wdg;
		@(posedge sys_clk_i);
		wdg_underflow_i <= 1'h1;
		@(posedge sys_clk_i);
		wdg_underflow_i <= 1'h0;
	endtask

	task automatic ack;
		@(posedge sys_clk_i);
		warn_irq_ack_i <= 1'h1;
		@(posedge sys_clk_i);
		warn_irq_ack_i <= 1'h0;
		tick(2);
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Monitor: drive span, then one note per read answer or fetch cycle
	always @(posedge sys_clk_i) begin : mon
		logic [33:0] seen;
		logic [67:0] e;
		if (rst_pin_oe_o === 1'h1)
			span <= span + 1;
		else if (span != 0) begin
			last_span <= span;
			span <= 0;
		end
		if ((s_axi_rvalid && s_axi_rready) || vec_fetch_o === 1'h1) begin
			seen = vec_fetch_o ? {18'h0, vec_addr_o} : {s_axi_rresp, s_axi_rdata};
			e = exp_q.pop_front();
			check(seen & e[67:34], e[33:0]);
		end
		// Write response, compared at its handshake edge
		if (s_axi_bvalid === 1'h1 && s_axi_bready === 1'h1) begin
			e = exp_q.pop_front();
			check({s_axi_bresp, 32'h0} & e[67:34], e[33:0]);
		end
	end

	// Hang guard, far above the expected run length
	initial begin
		tick(20000);
		errors++;
		print_verdict();
	end

	initial begin
		void'($urandom(32'h7936));
		tick(12);
		rst_n_i <= 1'h1;
		seq(DS, 40);
		ok(rst_pin_o === 1'h0);
		rd(AS, FM, {rim_pkg::RESP_OKAY, 32'h3});
		$display("power-up done");
		wdg();
		seq(DS + MO, DS + MO + 4);
		rd(AC, 34'h3_0000_0001, 34'h0_0000_0001);
		wr(AC, 32'h0000_0000);
		rd(AC, 34'h3_0000_0001, 34'h0_0000_0000);
		$display("watchdog done");
		@(posedge sys_clk_i);
		opt_i <= 4'hC;
		plen <= 4'($urandom_range(3, 1));
		go <= 1'h1;
		@(posedge sys_clk_i);
		go <= 1'h0;
		seq(DL + MO, DL + MO + 6);
		rd(AC, 34'h3_0000_0011, 34'h0_0000_0000);
		$display("pin pulse done");
		opt_i <= 4'h4;
		wdg();
		seq(DS + MO, DS + MO + 4);
		len = $urandom_range(40, 20);
		lvd_below_i <= 1'h1;
		tick(len);
		lvd_below_i <= 1'h0;
		seq(len + DS - 2, len + DS + 4);
		rd(AC, 34'h3_0000_0011, 34'h0_0000_0010);
		wdg();
		seq(DS + MO, DS + MO + 4);
		rd(AC, 34'h3_0000_0011, 34'h0_0000_0011);
		wr(AC, 32'h0000_0000);
		$display("supply reset done");
		opt_i <= 4'h0;
		lvd_below_i <= 1'h1;
		avd_below_i <= 1'h1;
		tick(20);
		ok(span == 0 && cpu_rst_o === 1'h0);
		rd(AC, 34'h3_0000_0020, 34'h0_0000_0000);
		lvd_below_i <= 1'h0;
		tick(4);
		opt_i <= 4'h4;
		tick(5);
		ok(warn_irq_o === 1'h0);
		rd(AC, 34'h3_0000_0020, 34'h0_0000_0020);
		wr(AC, 32'h0000_0040);
		tick(2);
		ok(warn_irq_o === 1'h1);
		ack();
		ok(warn_irq_o === 1'h0);
		avd_below_i <= 1'h0;
		tick(5);
		ok(warn_irq_o === 1'h1);
		ack();
		avd_below_i <= 1'h1;
		tick(5);
		ok(warn_irq_o === 1'h1);
		ack();
		wr(AC, 32'h0000_0000);
		avd_below_i <= 1'h0;
		tick(5);
		wr(AC, 32'h0000_0040);
		tick(3);
		ok(warn_irq_o === 1'h0);
		wdg();
		avd_below_i <= 1'h1;
		tick(8);
		avd_below_i <= 1'h0;
		seq(DS + MO, DS + MO + 4);
		ok(warn_irq_o === 1'h0);
		$display("warning done");
		opt_i <= 4'h7;
		wr(AC, 32'h0000_0004);
		osc_ok_i <= 1'h0;
		tick(2);
		osc_ok_i <= 1'h1;
		tick(8);
		ok(safe_clk_sel_o === 1'h0);
		osc_ok_i <= 1'h0;
		tick(12);
		ok(safe_clk_sel_o === 1'h1 && guard_irq_o === 1'h1);
		rd(AC, 34'h3_0000_0002, 34'h0_0000_0002);
		osc_ok_i <= 1'h1;
		tick(12);
		ok(safe_clk_sel_o === 1'h0);
		rd(AC, 34'h3_0000_0002, 34'h0_0000_0002);
		rd(AC, 34'h3_0000_0002, 34'h0_0000_0000);
		$display("clock guard done");
		rd(4'h8, FM, {rim_pkg::RESP_SLVERR, 32'h0});
		wr(4'h8, $urandom());
		wr(AS, $urandom());
		rd(AS, FM, {rim_pkg::RESP_OKAY, 32'h3});
		$display("register bus done");
		// Frozen block must ignore an underflow pulse
		ce_i <= 1'h0;
		wdg();
		tick(2);
		ok(cpu_rst_o === 1'h0 && rst_pin_oe_o === 1'h0);
		ce_i <= 1'h1;
		tick(2);
		ok(cpu_rst_o === 1'h0);
		$display("clock enable done");
		print_verdict();
	end
endmodule // rim_top_tb
